// file: src/scl_device.sv
/*
 * Device end of the configuration loader: synchroniser, receive FIFO and
 * the receiving state machine scl_device.
 * Assumes the host clocks the link well below half the system clock and
 * that the user side drains configuration words and reports end or error.
 */
`timescale 1ns/100ps

// ------------------------------------------------------------
// two-stage synchroniser
// ------------------------------------------------------------
module scl_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;

	always_comb begin
		meta_nxt = async_i;
		sync_nxt = meta_r;
		if (!rst_b_i) begin
			meta_nxt = '0;
			sync_nxt = '0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		meta_r <= meta_nxt;
		sync_r <= sync_nxt;
	end

	assign sync_o = sync_r;
endmodule

// ------------------------------------------------------------
// synchronous FIFO
// ------------------------------------------------------------
module scl_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         flush_i,
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	output logic      [W-1:0] out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0]   FULL_CNT = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	logic [W-1:0]  mem [DEPTH];
	logic [PW-1:0] wr_r;
	logic [PW-1:0] wr_nxt;
	logic [PW-1:0] rd_r;
	logic [PW-1:0] rd_nxt;
	logic [PW:0]   cnt_r;
	logic [PW:0]   cnt_nxt;
	logic          push;
	logic          pop;

	assign in_ready_o  = (cnt_r != FULL_CNT);
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem[rd_r];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_comb begin
		wr_nxt  = wr_r;
		rd_nxt  = rd_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wr_nxt = (wr_r == LAST_PTR) ? '0 : wr_r + 1'b1;
		end
		if (pop) begin
			rd_nxt = (rd_r == LAST_PTR) ? '0 : rd_r + 1'b1;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
		if (!rst_b_i || flush_i) begin
			wr_nxt  = '0;
			rd_nxt  = '0;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		wr_r  <= wr_nxt;
		rd_r  <= rd_nxt;
		cnt_r <= cnt_nxt;
		if (push) begin
			mem[wr_r] <= in_data_i;
		end
	end
endmodule

// ------------------------------------------------------------
// device end
// ------------------------------------------------------------
module scl_device (
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_b_i,
	scl_link_if.device                      link,
	input  wire logic                       byte_load_mode_i,
	input  wire logic                       load_done_i,
	input  wire logic                       load_error_i,
	output logic [scl_pkg::DATA_W-1:0]      cfg_word_o,
	output logic                            cfg_word_valid_o,
	input  wire logic                       cfg_word_ready_i,
	output logic                            loading_o,
	output logic                            user_mode_o,
	output logic                            error_o
);
	localparam int SW = scl_pkg::DATA_W + 4;
	localparam logic [scl_pkg::EDGE_CNT_W-1:0] LAST_FALL =
		scl_pkg::EDGE_CNT_W'(scl_pkg::INIT_FALL_EDGES - 1);

	logic [SW-1:0]                   sync_w;
	logic                            s_clk;
	logic [scl_pkg::DATA_W-1:0]      s_data;
	logic                            s_reconf_n;
	logic                            s_fault_n;
	logic                            s_done;
	logic                            rise;
	logic                            fall;

	scl_pkg::scl_dev_state_t         st_r;
	scl_pkg::scl_dev_state_t         st_nxt;
	logic                            clk_q_r;
	logic                            clk_q_nxt;
	logic [scl_pkg::DATA_W-1:0]      shift_r;
	logic [scl_pkg::DATA_W-1:0]      shift_nxt;
	logic [scl_pkg::BIT_CNT_W-1:0]   bit_r;
	logic [scl_pkg::BIT_CNT_W-1:0]   bit_nxt;
	logic [scl_pkg::EDGE_CNT_W-1:0]  edge_r;
	logic [scl_pkg::EDGE_CNT_W-1:0]  edge_nxt;
	logic                            fault_oe_r;
	logic                            fault_oe_nxt;
	logic                            cmpl_oe_r;
	logic                            cmpl_oe_nxt;
	logic [scl_pkg::DATA_W-1:0]      out_r;
	logic [scl_pkg::DATA_W-1:0]      out_nxt;
	logic                            out_v_r;
	logic                            out_v_nxt;

	logic [scl_pkg::DATA_W-1:0]      push_data;
	logic                            push;
	logic                            f_ready;
	logic [scl_pkg::DATA_W-1:0]      f_data;
	logic                            f_valid;
	logic                            f_pop;

	// clock and data share one synchroniser so they stay aligned
	scl_sync #(.W(SW)) u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.async_i   ({link.cfg_bit_clock, link.cfg_data, link.reconfig_request_n,
		              link.cfg_fault_line_n, link.config_complete}),
		.sync_o    (sync_w)
	);

	assign {s_clk, s_data, s_reconf_n, s_fault_n, s_done} = sync_w;
	assign rise = s_clk & ~clk_q_r;
	assign fall = ~s_clk & clk_q_r;

	scl_fifo #(.W(scl_pkg::DATA_W), .DEPTH(scl_pkg::FIFO_DEPTH)) u_fifo (
		.sys_clk_i   (sys_clk_i),
		.rst_b_i     (rst_b_i),
		.flush_i     (st_r == scl_pkg::DEV_RESET),
		.in_data_i   (push_data),
		.in_valid_i  (push),
		.in_ready_o  (f_ready),
		.out_data_o  (f_data),
		.out_valid_o (f_valid),
		.out_ready_i (f_pop)
	);

	// output stage keeps the user-side word straight from a flop
	assign f_pop = f_valid & (~out_v_r | cfg_word_ready_i);

	// ------------------------------------------------------------
	// receive state machine
	// ------------------------------------------------------------
	always_comb begin
		st_nxt       = st_r;
		clk_q_nxt    = s_clk;
		shift_nxt    = shift_r;
		bit_nxt      = bit_r;
		edge_nxt     = edge_r;
		fault_oe_nxt = fault_oe_r;
		cmpl_oe_nxt  = cmpl_oe_r;
		push         = 1'b0;
		push_data    = s_data;
		out_nxt      = f_pop ? f_data : out_r;
		out_v_nxt    = f_pop ? 1'b1 : (out_v_r & ~cfg_word_ready_i);
		case (st_r)
			scl_pkg::DEV_RESET: begin
				fault_oe_nxt = 1'b1;
				cmpl_oe_nxt  = 1'b1;
				bit_nxt      = '0;
				if (s_reconf_n) begin
					fault_oe_nxt = 1'b0;
					st_nxt       = scl_pkg::DEV_WAIT;
				end
			end
			scl_pkg::DEV_WAIT: begin
				// other chain members may still hold the fault line
				if (s_fault_n) begin
					st_nxt = scl_pkg::DEV_LOAD;
				end
			end
			scl_pkg::DEV_LOAD: begin
				if (rise && !s_done) begin
					if (byte_load_mode_i) begin
						push = 1'b1;
					end else begin
						shift_nxt = {s_data[scl_pkg::SERIAL_BIT],
						             shift_r[scl_pkg::DATA_W-1:1]};
						bit_nxt   = bit_r + 1'b1;
						push      = (bit_r == scl_pkg::LAST_BIT);
						push_data = shift_nxt;
					end
				end
				if (load_done_i) begin
					cmpl_oe_nxt = 1'b0;
				end
				// overrun: the host owns the clock and cannot be stalled
				if (load_error_i || (push && !f_ready)) begin
					fault_oe_nxt = 1'b1;
					cmpl_oe_nxt  = 1'b1;
					st_nxt       = scl_pkg::DEV_ERROR;
				end else if (!s_fault_n) begin
					cmpl_oe_nxt = 1'b1;
					st_nxt      = scl_pkg::DEV_ERROR;
				end else if (s_done) begin
					edge_nxt = '0;
					st_nxt   = scl_pkg::DEV_INIT;
				end
			end
			scl_pkg::DEV_INIT: begin
				// internal init, no user startup clock consulted
				if (fall) begin
					edge_nxt = edge_r + 1'b1;
					if (edge_r == LAST_FALL) begin
						st_nxt = scl_pkg::DEV_USER;
					end
				end
			end
			scl_pkg::DEV_USER: begin
				cmpl_oe_nxt = 1'b0;
			end
			scl_pkg::DEV_ERROR: begin
				// held until the host requests a new cycle
				cmpl_oe_nxt = 1'b1;
			end
			default: begin
				st_nxt = scl_pkg::DEV_RESET;
			end
		endcase
		if (!s_reconf_n) begin
			st_nxt = scl_pkg::DEV_RESET;
		end
		if (!rst_b_i) begin
			st_nxt       = scl_pkg::DEV_RESET;
			clk_q_nxt    = 1'b0;
			shift_nxt    = '0;
			bit_nxt      = '0;
			edge_nxt     = '0;
			fault_oe_nxt = 1'b1;
			cmpl_oe_nxt  = 1'b1;
			out_nxt      = '0;
			out_v_nxt    = 1'b0;
		end else if (st_r == scl_pkg::DEV_RESET) begin
			out_v_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		st_r       <= st_nxt;
		clk_q_r    <= clk_q_nxt;
		shift_r    <= shift_nxt;
		bit_r      <= bit_nxt;
		edge_r     <= edge_nxt;
		fault_oe_r <= fault_oe_nxt;
		cmpl_oe_r  <= cmpl_oe_nxt;
		out_r      <= out_nxt;
		out_v_r    <= out_v_nxt;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	logic loading_r;
	logic user_r;
	logic err_r;

	always_ff @(posedge sys_clk_i) begin
		loading_r <= rst_b_i & (st_nxt == scl_pkg::DEV_LOAD);
		user_r    <= rst_b_i & (st_nxt == scl_pkg::DEV_USER);
		err_r     <= rst_b_i & (st_nxt == scl_pkg::DEV_ERROR);
	end

	// open-drain lines: the driven value is always low
	assign link.dev_fault_o     = 1'b0;
	assign link.dev_fault_oe    = fault_oe_r;
	assign link.dev_complete_o  = 1'b0;
	assign link.dev_complete_oe = cmpl_oe_r;
	assign cfg_word_o           = out_r;
	assign cfg_word_valid_o     = out_v_r;
	assign loading_o            = loading_r;
	assign user_mode_o          = user_r;
	assign error_o              = err_r;
endmodule

// file: src/scl_host.sv
/*
 * Host end of the configuration loader: pulses the reconfiguration request,
 * divides the system clock into the link clock and shifts out bytes.
 * Assumes scl_sync from the device file is compiled first.
 */
`timescale 1ns/100ps
module scl_host (
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_b_i,
	scl_link_if.host                       link,
	input  wire logic                      start_i,
	input  wire logic                      byte_load_mode_i,
	input  wire logic [scl_pkg::DATA_W-1:0] src_data_i,
	input  wire logic                      src_valid_i,
	output logic                           src_ready_o,
	output logic                           busy_o,
	output logic                           done_o,
	output logic                           error_o
);
	localparam logic [scl_pkg::DIV_CNT_W-1:0]   HALF_LAST =
		scl_pkg::DIV_CNT_W'(scl_pkg::LINK_HALF_CYC - 1);
	localparam logic [scl_pkg::PULSE_CNT_W-1:0] PULSE_LAST =
		scl_pkg::PULSE_CNT_W'(scl_pkg::CFG_PULSE_CYC - 1);
	localparam logic [scl_pkg::EDGE_CNT_W-1:0]  LAST_FALL =
		scl_pkg::EDGE_CNT_W'(scl_pkg::INIT_FALL_EDGES - 1);

	logic [1:0]                       sync_w;
	logic                             s_fault_n;
	logic                             s_done;

	scl_pkg::scl_host_state_t         st_r;
	scl_pkg::scl_host_state_t         st_nxt;
	logic                             reconf_n_r;
	logic                             reconf_n_nxt;
	logic                             clk_r;
	logic                             clk_nxt;
	logic [scl_pkg::DATA_W-1:0]       data_r;
	logic [scl_pkg::DATA_W-1:0]       data_nxt;
	logic [scl_pkg::DATA_W-1:0]       byte_r;
	logic [scl_pkg::DATA_W-1:0]       byte_nxt;
	logic                             have_r;
	logic                             have_nxt;
	logic                             ready_r;
	logic                             ready_nxt;
	logic                             mode_r;
	logic                             mode_nxt;
	logic [scl_pkg::BIT_CNT_W-1:0]    bit_r;
	logic [scl_pkg::BIT_CNT_W-1:0]    bit_nxt;
	logic [scl_pkg::DIV_CNT_W-1:0]    div_r;
	logic [scl_pkg::DIV_CNT_W-1:0]    div_nxt;
	logic [scl_pkg::PULSE_CNT_W-1:0]  pulse_r;
	logic [scl_pkg::PULSE_CNT_W-1:0]  pulse_nxt;
	logic [scl_pkg::EDGE_CNT_W-1:0]   edge_r;
	logic [scl_pkg::EDGE_CNT_W-1:0]   edge_nxt;

	scl_sync #(.W(2)) u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.async_i   ({link.cfg_fault_line_n, link.config_complete}),
		.sync_o    (sync_w)
	);

	assign {s_fault_n, s_done} = sync_w;

	// ------------------------------------------------------------
	// transmit state machine
	// ------------------------------------------------------------
	always_comb begin
		st_nxt       = st_r;
		reconf_n_nxt = reconf_n_r;
		clk_nxt      = clk_r;
		data_nxt     = data_r;
		byte_nxt     = byte_r;
		have_nxt     = have_r;
		ready_nxt    = 1'b0;
		mode_nxt     = mode_r;
		bit_nxt      = bit_r;
		div_nxt      = div_r;
		pulse_nxt    = pulse_r;
		edge_nxt     = edge_r;
		case (st_r)
			scl_pkg::HST_IDLE, scl_pkg::HST_DONE, scl_pkg::HST_ERROR: begin
				// restart only on command, never by itself
				if (start_i) begin
					mode_nxt     = byte_load_mode_i;
					reconf_n_nxt = 1'b0;
					pulse_nxt    = '0;
					have_nxt     = 1'b0;
					clk_nxt      = 1'b0;
					st_nxt       = scl_pkg::HST_PULSE;
				end
			end
			scl_pkg::HST_PULSE: begin
				pulse_nxt = pulse_r + 1'b1;
				if (pulse_r == PULSE_LAST) begin
					reconf_n_nxt = 1'b1;
					st_nxt       = scl_pkg::HST_WAIT;
				end
			end
			scl_pkg::HST_WAIT: begin
				div_nxt = '0;
				if (s_fault_n) begin
					st_nxt = scl_pkg::HST_SEND;
				end
			end
			scl_pkg::HST_SEND: begin
				if (!s_fault_n) begin
					st_nxt = scl_pkg::HST_ERROR;
				end else if (s_done && !clk_r) begin
					div_nxt  = '0;
					edge_nxt = '0;
					st_nxt   = scl_pkg::HST_TAIL;
				end else if (!clk_r) begin
					if (!have_r) begin
						ready_nxt = ~(ready_r & src_valid_i);
						if (ready_r && src_valid_i) begin
							byte_nxt = src_data_i;
							have_nxt = 1'b1;
							bit_nxt  = '0;
						end
					end else begin
						data_nxt = mode_r ? byte_r :
						           {{(scl_pkg::DATA_W-1){1'b0}}, byte_r[bit_r]};
						div_nxt  = div_r + 1'b1;
						if (div_r == HALF_LAST) begin
							div_nxt = '0;
							clk_nxt = 1'b1;
						end
					end
				end else begin
					div_nxt = div_r + 1'b1;
					if (div_r == HALF_LAST) begin
						div_nxt = '0;
						clk_nxt = 1'b0;
						bit_nxt = bit_r + 1'b1;
						if (mode_r || bit_r == scl_pkg::LAST_BIT) begin
							have_nxt = 1'b0;
						end
					end
				end
			end
			scl_pkg::HST_TAIL: begin
				div_nxt = div_r + 1'b1;
				if (div_r == HALF_LAST) begin
					div_nxt = '0;
					clk_nxt = ~clk_r;
					if (clk_r) begin
						edge_nxt = edge_r + 1'b1;
						if (edge_r == LAST_FALL) begin
							st_nxt = scl_pkg::HST_DONE;
						end
					end
				end
			end
			default: begin
				st_nxt = scl_pkg::HST_IDLE;
			end
		endcase
		if (!rst_b_i) begin
			st_nxt       = scl_pkg::HST_IDLE;
			reconf_n_nxt = 1'b1;
			clk_nxt      = 1'b0;
			data_nxt     = '0;
			byte_nxt     = '0;
			have_nxt     = 1'b0;
			ready_nxt    = 1'b0;
			mode_nxt     = 1'b0;
			bit_nxt      = '0;
			div_nxt      = '0;
			pulse_nxt    = '0;
			edge_nxt     = '0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		st_r       <= st_nxt;
		reconf_n_r <= reconf_n_nxt;
		clk_r      <= clk_nxt;
		data_r     <= data_nxt;
		byte_r     <= byte_nxt;
		have_r     <= have_nxt;
		ready_r    <= ready_nxt;
		mode_r     <= mode_nxt;
		bit_r      <= bit_nxt;
		div_r      <= div_nxt;
		pulse_r    <= pulse_nxt;
		edge_r     <= edge_nxt;
	end

	logic busy_r;
	logic done_r;
	logic err_r;

	always_ff @(posedge sys_clk_i) begin
		busy_r <= rst_b_i & (st_nxt != scl_pkg::HST_IDLE) & (st_nxt != scl_pkg::HST_DONE)
		          & (st_nxt != scl_pkg::HST_ERROR);
		done_r <= rst_b_i & (st_nxt == scl_pkg::HST_DONE);
		err_r  <= rst_b_i & (st_nxt == scl_pkg::HST_ERROR);
	end

	// every chain member sees these same lines
	assign link.reconfig_request_n = reconf_n_r;
	assign link.cfg_bit_clock      = clk_r;
	assign link.cfg_data           = data_r;
	assign src_ready_o             = ready_r;
	assign busy_o                  = busy_r;
	assign done_o                  = done_r;
	assign error_o                 = err_r;
endmodule

// file: src/scl_link_if.sv
/*
 * Configuration link between host and device.
 * Assumes the bench drives chain_*_oe to model further devices on the
 * shared open-drain lines; pull-ups make released lines read high.
 */
`timescale 1ns/100ps
interface scl_link_if;
	logic                         reconfig_request_n;
	logic                         cfg_bit_clock;
	logic [scl_pkg::DATA_W-1:0]   cfg_data;
	logic                         dev_fault_o;
	logic                         dev_fault_oe;
	logic                         dev_complete_o;
	logic                         dev_complete_oe;
	logic                         chain_fault_oe;
	logic                         chain_complete_oe;
	logic                         cfg_fault_line_n;
	logic                         config_complete;

	// open-drain wired-and with pull-up
	assign cfg_fault_line_n = ~(dev_fault_oe | chain_fault_oe);
	assign config_complete  = ~(dev_complete_oe | chain_complete_oe);

	modport device (
		input  reconfig_request_n,
		input  cfg_bit_clock,
		input  cfg_data,
		input  cfg_fault_line_n,
		input  config_complete,
		output dev_fault_o,
		output dev_fault_oe,
		output dev_complete_o,
		output dev_complete_oe
	);

	modport host (
		output reconfig_request_n,
		output cfg_bit_clock,
		output cfg_data,
		input  cfg_fault_line_n,
		input  config_complete
	);
endinterface

// file: src/scl_pkg.sv
/*
 * Shared constants and state types of the serial configuration loader link.
 * Assumes a 100 MHz system clock on both ends.
 */
package scl_pkg;
	// ------------------------------------------------------------
	// widths and depths
	// ------------------------------------------------------------
	localparam int DATA_W        = 8;
	localparam int FIFO_DEPTH    = 16;
	localparam int SERIAL_BIT    = 0;
	localparam int BIT_CNT_W     = 3;
	localparam int DIV_CNT_W     = 4;
	localparam int PULSE_CNT_W   = 8;
	localparam int EDGE_CNT_W    = 2;
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int SYS_PERIOD_NS   = 10;
	localparam int CFG_PULSE_NS    = 500;
	localparam int CFG_PULSE_CYC   = (CFG_PULSE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int LINK_PERIOD_NS  = 80;
	localparam int LINK_HALF_CYC   = (LINK_PERIOD_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int INIT_FALL_EDGES = 2;

	// ------------------------------------------------------------
	// state machines
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DEV_RESET,
		DEV_WAIT,
		DEV_LOAD,
		DEV_INIT,
		DEV_USER,
		DEV_ERROR
	} scl_dev_state_t;

	typedef enum logic [2:0] {
		HST_IDLE,
		HST_PULSE,
		HST_WAIT,
		HST_SEND,
		HST_TAIL,
		HST_DONE,
		HST_ERROR
	} scl_host_state_t;
endpackage

// file: verification/scl_link_chk.sv
/*
 * Checker on the shared configuration lines of scl_link_if.
 * Assumes one host and one device, further chain devices driven by the bench.
 */
`timescale 1ns/100ps
module scl_link_chk (
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_b_i,
	input  wire logic                       reconfig_request_n,
	input  wire logic                       cfg_bit_clock,
	input  wire logic [scl_pkg::DATA_W-1:0] cfg_data,
	input  wire logic                       dev_fault_oe,
	input  wire logic                       dev_complete_oe,
	input  wire logic                       cfg_fault_line_n,
	input  wire logic                       config_complete
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	// ----------
	// properties
	// ----------
	property p_fault_hold;
		$rose(dev_fault_oe) |-> dev_fault_oe [*8];
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");
	// depth 5 covers the synchroniser and state flops
	property p_abort;
		!reconfig_request_n && !$past(reconfig_request_n, 5) |-> dev_fault_oe && dev_complete_oe;
	endproperty
	a_abort: assert property (p_abort) else $error("no abort");
	property p_pulse;
		$fell(reconfig_request_n) |-> ##49 !reconfig_request_n ##1 reconfig_request_n;
	endproperty
	a_pulse: assert property (p_pulse) else $error("bad request pulse");
	property p_init_edges;
		disable iff (!rst_b_i || !cfg_fault_line_n)
		$rose(config_complete) |-> ##[1:40] $fell(cfg_bit_clock) ##[1:16] $fell(cfg_bit_clock);
	endproperty
	a_init_edges: assert property (p_init_edges) else $error("no tail edges");
	property p_data_stable;
		disable iff (!rst_b_i || !cfg_fault_line_n)
		$rose(cfg_bit_clock) |-> ($past(cfg_data, 3) == cfg_data) ##1 ($stable(cfg_data) [*3]);
	endproperty
	a_data_stable: assert property (p_data_stable) else $error("data moved");
	property p_clk_high;
		disable iff (!rst_b_i || !cfg_fault_line_n)
		$rose(cfg_bit_clock) |-> cfg_bit_clock [*4] ##1 !cfg_bit_clock;
	endproperty
	a_clk_high: assert property (p_clk_high) else $error("bad clock high");
	property p_fault_stop;
		$fell(cfg_fault_line_n) |-> ##6 (!$rose(cfg_bit_clock)) [*8];
	endproperty
	a_fault_stop: assert property (p_fault_stop) else $error("clock after fault");
	property p_complete_rel;
		$fell(dev_complete_oe) |-> reconfig_request_n && cfg_fault_line_n;
	endproperty
	a_complete_rel: assert property (p_complete_rel) else $error("bad release");
	// ----------
	// covers
	// ----------
	c_user: cover property ($rose(config_complete));
	c_fault: cover property ($fell(cfg_fault_line_n) && reconfig_request_n);
	c_pulse: cover property ($rose(reconfig_request_n));
endmodule

// file: verification/scl_tb_top.sv
/*
 * Bench: host and device joined by one scl_link_if, random bytes.
 * Assumes design files and scl_link_chk compiled first.
 */
`timescale 1ns/100ps
module scl_tb_top;
	logic        sys_clk_i = 1'h0;
	logic        rst_b_i = 1'h0;
	logic        start_i = 1'h0;
	logic        mode = 1'h0;
	logic [7:0]  src_data_i = '0;
	logic        src_valid_i = 1'h0;
	logic        load_done_i = 1'h0;
	logic        load_error_i = 1'h0;
	logic        cfg_word_ready_i = 1'h0;
	logic        h_rdy;
	logic        h_busy;
	logic        h_done;
	logic        h_err;
	logic [7:0]  d_word;
	logic        d_valid;
	logic        d_user;
	logic        d_err;
	logic        d_load;
	logic [31:0] seed = 32'h3f3;
	logic [7:0]  tx_q [0:31];
	logic        tk = 1'h0;
	logic        stall = 1'h0;
	int          sent;
	int          got;
	int          nb;
	int          n_tx;
	int          fails;
	int          check_count;

	scl_link_if link ();
	scl_host i_scl_host (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link(link.host),
		.start_i(start_i), .byte_load_mode_i(mode), .src_data_i(src_data_i),
		.src_valid_i(src_valid_i), .src_ready_o(h_rdy), .busy_o(h_busy),
		.done_o(h_done), .error_o(h_err));
	scl_device i_scl_device (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link(link.device),
		.byte_load_mode_i(mode), .load_done_i(load_done_i), .load_error_i(load_error_i),
		.cfg_word_o(d_word), .cfg_word_valid_o(d_valid), .cfg_word_ready_i(cfg_word_ready_i),
		.loading_o(d_load), .user_mode_o(d_user), .error_o(d_err));
	scl_link_chk i_scl_link_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.reconfig_request_n(link.reconfig_request_n), .cfg_bit_clock(link.cfg_bit_clock),
		.cfg_data(link.cfg_data), .dev_fault_oe(link.dev_fault_oe),
		.dev_complete_oe(link.dev_complete_oe), .cfg_fault_line_n(link.cfg_fault_line_n),
		.config_complete(link.config_complete));

	always #5 sys_clk_i = ~sys_clk_i;

	// ----------
	// helpers
	// ----------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] exp_link(input int b);
		return mode ? tx_q[b] : {7'h0, tx_q[b/8][b%8]};
	endfunction
	function automatic logic cond(input int s);
		case (s)
			0: return h_done & d_user;
			1: return h_err & d_err;
			2: return 1'(got >= n_tx);
			default: return 1'(got >= 3);
		endcase
	endfunction
	task automatic chk_word(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t word %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t flag %b exp %b", $time, g, e);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wt(input int s, input int n);
		for (int i = 0; i < n; i++) begin
			if (cond(s) === 1'h1)
				return;
			@(negedge sys_clk_i);
		end
		fails++;
		$display("MISMATCH %0t wait %0d timed out", $time, s);
		give_verdict();
	endtask

	// ----------
	// source, sink and wire watcher
	// ----------
	// source holds each byte until the edge that takes it
	always @(negedge sys_clk_i) begin
		if (tk)
			sent++;
		src_valid_i = 1'(sent < n_tx);
		src_data_i = tx_q[sent % 32];
		tk = src_valid_i && h_rdy;
		cfg_word_ready_i = !stall && (rnd() % 3 != 0);
		if (d_valid === 1'h1 && cfg_word_ready_i) begin
			chk_word(d_word, tx_q[got % 32]);
			got++;
		end
	end
	always @(posedge link.cfg_bit_clock) begin
		if (h_busy === 1'h1 && nb < (mode ? n_tx : 8 * n_tx)) begin
			chk_word(link.cfg_data, exp_link(nb));
			nb++;
		end
	end

	// ----------
	// scenarios
	// ----------
	task automatic start_tx(input logic bm, input int n);
		for (int i = 0; i < n; i++)
			tx_q[i] = 8'(rnd());
		mode = bm;
		sent = 0;
		got = 0;
		nb = 0;
		tk = 1'h0;
		n_tx = n;
		start_i = 1'h1;
		@(negedge sys_clk_i);
		start_i = 1'h0;
		repeat (60) @(negedge sys_clk_i);
		chk_bit(d_user | link.config_complete, 1'h0);
	endtask
	task automatic run(input logic bm, input int n, input logic hold);
		start_tx(bm, n);
		wt(2, 3000);
		chk_bit(d_load, 1'h1);
		link.chain_complete_oe = hold;
		load_done_i = 1'h1;
		@(negedge sys_clk_i);
		load_done_i = 1'h0;
		if (hold) begin
			repeat (100) @(negedge sys_clk_i);
			chk_bit(d_user, 1'h0);
			chk_bit(h_done, 1'h0);
			link.chain_complete_oe = 1'h0;
		end
		wt(0, 400);
		chk_bit(d_user & h_done, 1'h1);
		chk_bit(d_load, 1'h0);
	endtask
	// 0: own error, 1: another chain device faults, 2: sink stalls into overrun
	task automatic fault_run(input int k);
		stall = 1'(k == 2);
		start_tx(1'h1, (k == 2) ? 24 : 20);
		if (k < 2)
			wt(3, 1000);
		load_error_i = 1'(k == 0);
		link.chain_fault_oe = 1'(k == 1);
		@(negedge sys_clk_i);
		load_error_i = 1'h0;
		wt(1, 600);
		chk_bit(link.cfg_fault_line_n, 1'h0);
		repeat (200) @(negedge sys_clk_i);
		chk_bit(h_busy | ~link.reconfig_request_n, 1'h0);
		link.chain_fault_oe = 1'h0;
		stall = 1'h0;
		n_tx = 0;
		// words held at the error must drain before the next image is drawn
		repeat (80) @(negedge sys_clk_i);
		chk_bit(d_valid, 1'h0);
	endtask

	initial begin
		link.chain_fault_oe = 1'h0;
		link.chain_complete_oe = 1'h0;
		repeat (10) @(negedge sys_clk_i);
		rst_b_i = 1'h1;
		run(1'h1, 20, 1'h0);
		run(1'h0, 6, 1'h1);
		run(1'h1, 1, 1'h0);
		for (int k = 0; k < 3; k++)
			fault_run(k);
		run(1'h0, 3, 1'h0);
		give_verdict();
	end
endmodule
